// ==== design/sdfw_pkg.sv ====
package sdfw_pkg;
  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int DATA_W = 16;
  localparam int BUS_W = 32;
  localparam int ADDR_W = 12;
  localparam int FIFO_DEPTH = 4;

  // ----------------------------------------
  // Data window decode
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] DATA_BASE = 12'h060;
  localparam int DATA_WORDS = 36;
  localparam logic [ADDR_W-1:0] DATA_LAST = 12'h0EC;
  localparam logic [ADDR_W-1:0] FIFO_WINDOW_9_OFF = 12'h084;
  localparam logic [ADDR_W-1:0] FIFO_WINDOW_10_OFF = 12'h088;
  localparam logic [ADDR_W-1:0] FIFO_WINDOW_12_OFF = 12'h090;
  localparam logic [ADDR_W-1:0] FIFO_WINDOW_14_OFF = 12'h098;

  // ----------------------------------------
  // Reset values and field layout
  // ----------------------------------------
  localparam logic [BUS_W-1:0] PRDATA_RST = 32'h00000000;
  localparam logic [BUS_W-DATA_W-1:0] UPPER_RESERVED_BITS = 16'h0000;
endpackage : sdfw_pkg

// ==== design/sdfw_stream_if.sv ====
`timescale 1ns/1ps
interface sdfw_stream_if #(parameter int W = 16) ();
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : sdfw_stream_if

// ==== design/sdfw_fifo.sv ====
`timescale 1ns/1ps
module sdfw_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4,
  parameter int AW = $clog2(DEPTH)
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Hold empty
  input wire logic flush,
  // Streams
  sdfw_stream_if.snk push,
  sdfw_stream_if.src pop,
  // Fill level
  output logic [AW:0] level
);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [WIDTH-1:0] nxt_mem [DEPTH];
  logic [AW-1:0] wptr_ff, nxt_wptr, rptr_ff, nxt_rptr;
  logic [AW:0] cnt_ff, nxt_cnt;
  logic do_push, do_pop;

  assign push.ready = (cnt_ff != (AW+1)'(DEPTH)) && !flush;
  assign pop.valid = (cnt_ff != '0) && !flush;
  assign pop.data = mem_ff[rptr_ff];
  assign level = cnt_ff;

  always_comb begin
    do_push = push.valid && push.ready;
    do_pop = pop.valid && pop.ready;
    nxt_mem = mem_ff;
    nxt_wptr = wptr_ff;
    nxt_rptr = rptr_ff;
    nxt_cnt = cnt_ff;
    if (flush) begin
      nxt_wptr = '0;
      nxt_rptr = '0;
      nxt_cnt = '0;
    end else begin
      if (do_push) begin
        nxt_mem[wptr_ff] = push.data;
        nxt_wptr = (wptr_ff == AW'(DEPTH-1)) ? '0 : wptr_ff + 1'b1;
      end
      if (do_pop) begin
        nxt_rptr = (rptr_ff == AW'(DEPTH-1)) ? '0 : rptr_ff + 1'b1;
      end
      if (do_push && !do_pop) begin
        nxt_cnt = cnt_ff + 1'b1;
      end else if (do_pop && !do_push) begin
        nxt_cnt = cnt_ff - 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= '0;
      end
      wptr_ff <= '0;
      rptr_ff <= '0;
      cnt_ff <= '0;
    end else begin
      mem_ff <= nxt_mem;
      wptr_ff <= nxt_wptr;
      rptr_ff <= nxt_rptr;
      cnt_ff <= nxt_cnt;
    end
  end
endmodule : sdfw_fifo

// ==== design/sdfw_top.sv ====
// Contract
// - Every data window word carries the data in bits 15:0 and bits 31:16 always read zero.
// - A read of the window returns the oldest receive entry and removes it.
// - A write of the window puts the 16-bit value into the transmit FIFO as newest entry.
// - Writes enter the transmit FIFO only while the controller enable bit is 1.
// - While the controller enable bit is 0 both FIFOs are held empty.
// - The window decodes at thirty-six consecutive aligned words.
// - A write at any window word pushes the bus write data identically.
// - A read at any window word pops the receive FIFO identically.
// - FIFO entries are reached only by push and pop, never by address.
// - Data is right-justified both ways, with upper field bits cleared on reads.
`timescale 1ns/1ps
module sdfw_top import sdfw_pkg::*; #(
  parameter int DEPTH = FIFO_DEPTH,
  parameter int AW = $clog2(DEPTH)
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Controller control
  input wire logic controller_enable_bit,
  // Peripheral bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [BUS_W-1:0] pwdata,
  output logic [BUS_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Transmit side to shifter
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [DATA_W-1:0] tx_data,
  // Receive side from shifter
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [DATA_W-1:0] rx_data,
  // Fill levels
  output logic [AW:0] tx_level,
  output logic [AW:0] rx_level
);
  // ----------------------------------------
  // FIFO streams
  // ----------------------------------------
  sdfw_stream_if #(.W(DATA_W)) tx_in ();
  sdfw_stream_if #(.W(DATA_W)) tx_out ();
  sdfw_stream_if #(.W(DATA_W)) rx_in ();
  sdfw_stream_if #(.W(DATA_W)) rx_out ();

  logic fifo_flush;
  logic setup_ph;
  logic access_ph;
  logic win_hit;
  logic wr_req;
  logic rd_setup;
  logic [BUS_W-1:0] prdata_ff, nxt_prdata;
  logic pop_pend_ff, nxt_pop_pend;

  // ----------------------------------------
  // Address decode and bus handshake
  // ----------------------------------------
  always_comb begin
    setup_ph = psel && !penable;
    access_ph = psel && penable;
    // Every aligned word of the window is one alias
    win_hit = (paddr >= DATA_BASE) && (paddr <= DATA_LAST)
      && (paddr[1:0] == 2'b00);
    // Disabled controller drops writes quietly
    wr_req = access_ph && pwrite && win_hit && controller_enable_bit;
    rd_setup = setup_ph && !pwrite && win_hit;
  end

  // Only the head is visible, no entry index exists
  assign tx_in.valid = wr_req;
  assign tx_in.data = pwdata[DATA_W-1:0];
  // Full transmit FIFO stalls the write
  assign pready = !(wr_req && !tx_in.ready);
  assign pslverr = access_ph && !win_hit;
  assign rx_out.ready = access_ph && !pwrite && pop_pend_ff;
  assign fifo_flush = !controller_enable_bit;

  // ----------------------------------------
  // Read data capture
  // ----------------------------------------
  always_comb begin
    nxt_prdata = prdata_ff;
    nxt_pop_pend = pop_pend_ff;
    if (setup_ph) begin
      nxt_pop_pend = rd_setup && rx_out.valid;
      if (rd_setup && rx_out.valid) begin
        nxt_prdata = {UPPER_RESERVED_BITS, rx_out.data};
      end else begin
        nxt_prdata = PRDATA_RST;
      end
    end else if (access_ph) begin
      nxt_pop_pend = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_ff <= PRDATA_RST;
      pop_pend_ff <= 1'b0;
    end else begin
      prdata_ff <= nxt_prdata;
      pop_pend_ff <= nxt_pop_pend;
    end
  end

  assign prdata = prdata_ff;

  // ----------------------------------------
  // Shifter side
  // ----------------------------------------
  assign tx_valid = tx_out.valid;
  assign tx_data = tx_out.data;
  assign tx_out.ready = tx_ready;
  assign rx_in.valid = rx_valid;
  assign rx_in.data = rx_data;
  assign rx_ready = rx_in.ready;

  // ----------------------------------------
  // FIFOs
  // ----------------------------------------
  sdfw_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH), .AW(AW)) u_tx_fifo (
    .mclk (mclk),
    .rst_n (rst_n),
    .flush (fifo_flush),
    .push (tx_in),
    .pop (tx_out),
    .level (tx_level)
  );

  sdfw_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH), .AW(AW)) u_rx_fifo (
    .mclk (mclk),
    .rst_n (rst_n),
    .flush (fifo_flush),
    .push (rx_in),
    .pop (rx_out),
    .level (rx_level)
  );

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  upper_bits_zero_a: assert property (
    prdata[BUS_W-1:DATA_W] == '0
  ) else $error("upper data bits not zero");

  read_returns_head_a: assert property (
    (rd_setup && rx_out.valid)
    |=> prdata == {16'h0000, $past(rx_out.data)}
  ) else $error("read data is not the receive head");

  read_pops_once_a: assert property (
    (rd_setup && rx_out.valid && controller_enable_bit ##1
     access_ph && controller_enable_bit && !rx_in.valid)
    |=> rx_level == $past(rx_level) - 1'b1
  ) else $error("read did not pop exactly one entry");

  write_pushes_a: assert property (
    (access_ph && pwrite && win_hit && controller_enable_bit
     && tx_level < (AW+1)'(DEPTH) && !(tx_valid && tx_ready))
    |=> tx_level == $past(tx_level) + 1'b1
  ) else $error("write did not push one entry");

  no_push_disabled_a: assert property (
    !controller_enable_bit |-> !tx_in.valid && pready
  ) else $error("push while controller disabled");

  disabled_empty_a: assert property (
    !controller_enable_bit |=> (!controller_enable_bit)
      |-> (tx_level == '0 && rx_level == '0 && !tx_valid)
  ) else $error("FIFO not held empty while disabled");

  window_decode_a: assert property (
    (access_ph && paddr[1:0] == 2'b00 && paddr >= DATA_BASE
     && paddr <= DATA_LAST) |-> !pslverr
  ) else $error("window word refused");

  push_data_a: assert property (
    tx_in.valid |-> tx_in.data == pwdata[15:0] && pwrite
  ) else $error("pushed data differs from bus data");

  outside_no_push_a: assert property (
    (access_ph && !win_hit) |-> pslverr && !tx_in.valid && !rx_out.ready
  ) else $error("access outside window reached a FIFO");

  empty_read_zero_a: assert property (
    (rd_setup && !rx_out.valid) |=> prdata == '0 && !rx_out.ready
  ) else $error("empty read returned data or popped");

  // ----------------------------------------
  // Handshake and ordering checks
  // ----------------------------------------
  pop_only_pending_a: assert property (
    rx_out.ready |-> access_ph && !pwrite && $past(rd_setup && rx_out.valid)
  ) else $error("receive pop without a sampled read");

  write_never_pops_a: assert property (
    (access_ph && pwrite) |-> !rx_out.ready
  ) else $error("write access popped the receive FIFO");

  read_no_wait_a: assert property (
    (access_ph && !pwrite) |-> pready
  ) else $error("read access was stalled");

  full_write_stalls_a: assert property (
    (wr_req && tx_level == (AW+1)'(DEPTH)) |-> !pready && !tx_in.ready
  ) else $error("write into full transmit FIFO not stalled");

  free_write_ready_a: assert property (
    (wr_req && tx_level != (AW+1)'(DEPTH)) |-> pready && tx_in.valid
  ) else $error("write with room was stalled");

  disabled_write_ok_a: assert property (
    (access_ph && pwrite && win_hit && !controller_enable_bit) |-> pready && !pslverr
  ) else $error("disabled write was stalled or refused");

  disabled_closed_a: assert property (
    !controller_enable_bit |-> !rx_ready && !tx_valid
  ) else $error("disabled FIFO still open to the shifter");

  first_push_head_a: assert property (
    (wr_req && tx_in.ready && !tx_valid)
    |=> controller_enable_bit |-> tx_valid && tx_data == $past(pwdata[DATA_W-1:0])
  ) else $error("first written word is not the transmit head");

  tx_head_holds_a: assert property (
    (tx_valid && !tx_ready && controller_enable_bit)
    |=> controller_enable_bit |-> tx_valid && $stable(tx_data)
  ) else $error("transmit head moved without a pop");

  tx_drain_counts_a: assert property (
    (tx_valid && tx_ready && !tx_in.valid) |=> tx_level == $past(tx_level) - 1'b1
  ) else $error("transmit pop did not drop one entry");

  rx_first_entry_a: assert property (
    (rx_valid && rx_ready && !rx_out.valid)
    |=> controller_enable_bit |-> rx_out.valid && rx_out.data == $past(rx_data)
  ) else $error("first received word is not the receive head");

  rx_push_counts_a: assert property (
    (rx_valid && rx_ready && !rx_out.ready) |=> rx_level == $past(rx_level) + 1'b1
  ) else $error("receive push did not add one entry");

  rx_full_refuses_a: assert property (
    rx_level == (AW+1)'(DEPTH) |-> !rx_ready
  ) else $error("full receive FIFO still ready");

  rx_drain_counts_a: assert property (
    (rx_out.ready && rx_out.valid && !rx_valid) |=> rx_level == $past(rx_level) - 1'b1
  ) else $error("read pop did not drop one entry");

  one_pop_per_read_a: assert property (
    rx_out.ready |=> !rx_out.ready
  ) else $error("one read popped twice");

  pend_cleared_a: assert property (
    access_ph |=> !pop_pend_ff
  ) else $error("pop request outlived its access");

  read_data_holds_a: assert property (
    (access_ph && pready) |=> $stable(prdata)
  ) else $error("read data changed after the access");

  empty_read_keeps_a: assert property (
    (rd_setup && !rx_out.valid ##1 access_ph && controller_enable_bit && !rx_in.valid)
    |=> rx_level == $past(rx_level)
  ) else $error("empty read changed the receive level");

  // ----------------------------------------
  // Decode checks
  // ----------------------------------------
  window_span_a: assert property (
    DATA_LAST == DATA_BASE + ADDR_W'((DATA_WORDS - 1) * 4)
  ) else $error("window span differs from its word count");

  unaligned_refused_a: assert property (
    (access_ph && paddr[1:0] != 2'b00) |-> pslverr && !tx_in.valid
  ) else $error("unaligned access accepted");

  range_refused_a: assert property (
    (access_ph && (paddr < DATA_BASE || paddr > DATA_LAST)) |-> pslverr && !tx_in.valid
  ) else $error("access outside window accepted");

  refused_read_zero_a: assert property (
    (access_ph && !pwrite && !win_hit) |-> prdata == '0
  ) else $error("refused read returned data");

  slverr_in_access_a: assert property (
    pslverr |-> access_ph
  ) else $error("error response outside access phase");

  level_bounds_a: assert property (
    tx_level <= (AW+1)'(DEPTH) && rx_level <= (AW+1)'(DEPTH)
  ) else $error("FIFO level beyond depth");

endmodule : sdfw_top

// ==== tb/sdfw_shifter_model.sv ====
`timescale 1ns/1ps
module sdfw_shifter_model import sdfw_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Stall control
  input wire logic stall,
  // Transmit side
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [DATA_W-1:0] tx_data,
  // Receive side
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [DATA_W-1:0] rx_data
);
  logic [DATA_W-1:0] rxq[$];
  logic [DATA_W-1:0] txq[$];
  assign tx_ready = ~stall;
  initial begin
    rx_valid = 1'b0;
    rx_data = 16'h0000;
  end
  always @(posedge mclk) begin
    if (rst_n && tx_valid && tx_ready) txq.push_back(tx_data);
    if (rst_n && rx_valid && rx_ready) void'(rxq.pop_front());
  end
  // Idle data lines toggle so stale words never look valid
  always @(negedge mclk) begin
    rx_valid = (rxq.size() > 0);
    rx_data = rx_valid ? rxq[0] : ~rx_data;
  end
endmodule : sdfw_shifter_model

// ==== tb/spi_data_fifo_window_test.sv ====
`timescale 1ns/1ps
module spi_data_fifo_window_test import sdfw_pkg::*;;
  // ----
  // Wiring
  // ----
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic controller_enable_bit = 1'b0;
  logic stall = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 12'h000;
  logic [BUS_W-1:0] pwdata = 32'h0;
  logic [BUS_W-1:0] prdata, rd;
  logic pready, pslverr, tx_valid, tx_ready, rx_valid, rx_ready, err;
  logic [DATA_W-1:0] tx_data, rx_data;
  logic [2:0] tx_level, rx_level;
  logic [ADDR_W-1:0] offs[5] = '{DATA_BASE, FIFO_WINDOW_10_OFF, FIFO_WINDOW_14_OFF,
    DATA_LAST, FIFO_WINDOW_12_OFF};
  logic [DATA_W-1:0] words[5] = '{16'hA001, 16'h5AC3, 16'hFFFF, 16'h0010, 16'h0005};
  int error_cnt = 0;
  int compares = 0;
  always #2.5 mclk = ~mclk;
  sdfw_top #(.DEPTH(4)) dut_u (.mclk(mclk), .rst_n(rst_n),
    .controller_enable_bit(controller_enable_bit), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .tx_level(tx_level),
    .rx_level(rx_level));
  sdfw_shifter_model m_u (.mclk(mclk), .rst_n(rst_n), .stall(stall), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data));
  // ----
  // Tasks
  // ----
  task automatic chk(input logic [BUS_W-1:0] seen, input logic [BUS_W-1:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [BUS_W-1:0] d);
    int n;
    n = 0;
    @(negedge mclk);
    psel = 1'b1;
    pwrite = wr;
    paddr = a;
    pwdata = d;
    @(negedge mclk);
    penable = 1'b1;
    #1;
    while (pready !== 1'b1 && n < 50) begin
      @(negedge mclk);
      #1;
      n++;
    end
    chk(n >= 50, 1'b0);
    rd = prdata;
    err = pslverr;
    @(negedge mclk);
    psel = 1'b0;
    penable = 1'b0;
  endtask : apb
  task automatic results();
    if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  // ----
  // Tests
  // ----
  initial begin
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    chk(prdata, PRDATA_RST);
    apb(1'b1, FIFO_WINDOW_9_OFF, 32'h0000_1111);
    chk({err, tx_level}, 4'h0);
    controller_enable_bit = 1'b1;
    stall = 1'b1;
    for (int i = 0; i < 4; i++) apb(1'b1, offs[i], {16'hDEAD, words[i]});
    chk(tx_level, 3'h4);
    apb(1'b1, DATA_LAST + 12'h004, 32'h0000_0BAD);
    chk(err, 1'b1);
    apb(1'b0, DATA_BASE + 12'h002, 32'h0);
    chk(err, 1'b1);
    chk(tx_level, 3'h4);
    fork
      apb(1'b1, offs[4], {16'h0000, words[4]});
      begin
        repeat (4) @(negedge mclk);
        #1;
        chk(pready, 1'b0);
        stall = 1'b0;
      end
    join
    repeat (8) @(negedge mclk);
    chk(m_u.txq.size(), 5);
    foreach (words[i]) chk(m_u.txq[i], words[i]);
    m_u.rxq.push_back(16'hBEEF);
    m_u.rxq.push_back(16'h7E57);
    repeat (4) @(negedge mclk);
    chk(rx_level, 3'h2);
    apb(1'b0, DATA_BASE, 32'h0);
    chk(rd, 32'h0000_BEEF);
    apb(1'b0, DATA_LAST, 32'h0);
    chk(rd, 32'h0000_7E57);
    apb(1'b0, FIFO_WINDOW_9_OFF, 32'h0);
    chk(err, 1'b0);
    chk(rd, 32'h0);
    chk(rx_level, 3'h0);
    apb(1'b0, DATA_LAST + 12'h004, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    m_u.rxq.push_back(16'h1234);
    repeat (3) @(negedge mclk);
    controller_enable_bit = 1'b0;
    @(negedge mclk);
    chk({rx_level, tx_level, rx_ready}, 7'h0);
    controller_enable_bit = 1'b1;
    apb(1'b0, FIFO_WINDOW_12_OFF, 32'h0);
    chk(rd, 32'h0);
    results();
  end
  initial begin
    #20000;
    error_cnt++;
    results();
  end
endmodule : spi_data_fifo_window_test
